/* File: rtl/dbm_buf.sv */
// dbm_buf: two-entry word buffer with valid/ready on both sides.
// assumes one clock; the input side stalls through in_ready when both entries hold data.
`timescale 1ns/10ps
module dbm_buf #(
    parameter int W = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    logic [W-1:0] mem [2];
    logic         wptr;
    logic         rptr;
    logic [1:0]   count;
    logic         push;
    logic         pop;
    logic [1:0]   next_count;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rptr];

    always_comb begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + 2'h1;
        end else if (pop & ~push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count     <= 2'h0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
            wptr      <= 1'b0;
            rptr      <= 1'b0;
        end else begin
            count     <= next_count;
            // ready is registered, so it is computed from the next fill level
            in_ready  <= (next_count != 2'h2);
            out_valid <= (next_count != 2'h0);
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
endmodule : dbm_buf

/* File: rtl/dbm_core.sv */
// dbm_core: four-channel dma burst sequencer, independent or joint arbitration.
// assumes bus adapters that run each issued command as one ahb burst and pulse *_cmd_done.
`timescale 1ns/10ps
module dbm_core (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        core_joint,
    input  wire logic        cmd_load,
    input  wire logic [1:0]  cmd_ch,
    input  wire logic [31:0] cmd_src,
    input  wire logic [31:0] cmd_dst,
    input  wire logic [31:0] cmd_len,
    input  wire logic [31:0] cmd_ctrl,
    output logic             rd_cmd_valid,
    output logic [1:0]       rd_cmd_ch,
    output logic [31:0]      rd_cmd_addr,
    output logic [7:0]       rd_cmd_len,
    output logic [2:0]       rd_cmd_hburst,
    output logic [1:0]       rd_cmd_hsize,
    input  wire logic        rd_cmd_done,
    output logic             wr_cmd_valid,
    output logic [1:0]       wr_cmd_ch,
    output logic [31:0]      wr_cmd_addr,
    output logic [7:0]       wr_cmd_len,
    output logic [2:0]       wr_cmd_hburst,
    output logic [1:0]       wr_cmd_hsize,
    input  wire logic        wr_cmd_done,
    input  wire logic        rd_dvalid,
    input  wire logic [31:0] rd_data,
    output logic             rd_dready,
    output logic             wr_dvalid,
    output logic [31:0]      wr_data,
    input  wire logic        wr_dready,
    output logic [3:0]       ch_busy,
    output logic [3:0]       ch_done,
    output logic             cmd_refused,
    output logic             flushing
);
    localparam int NCH = dbm_pkg::NCH;

    logic [31:0]      ra   [NCH];
    logic [31:0]      wa   [NCH];
    logic [31:0]      rrem [NCH];
    logic [31:0]      wrem [NCH];
    logic [6:0]       rmax [NCH];
    logic [6:0]       wmax [NCH];
    logic [7:0]       fill [NCH];
    logic [NCH-1:0]   jbit;
    logic [7:0]       rl   [NCH];
    logic [7:0]       wl   [NCH];
    logic [NCH-1:0]   rdy_r;
    logic [NCH-1:0]   rdy_w;
    logic [NCH-1:0]   rd_el;
    logic [NCH-1:0]   wr_el;
    logic [NCH-1:0]   any_el;
    logic [1:0]       rd_last;
    logic [1:0]       wr_last;
    logic [1:0]       gnt;
    logic             last_joint;
    dbm_pkg::dbm_jst_e jst;
    dbm_pkg::dbm_jst_e next_jst;
    logic [2:0]       rd_pick;
    logic [2:0]       wr_pick;
    logic [2:0]       j_pick;
    logic             rd_go;
    logic [1:0]       rd_go_ch;
    logic [7:0]       rd_go_len;
    logic             wr_go;
    logic [1:0]       wr_go_ch;
    logic [7:0]       wr_go_len;
    logic             next_flushing;

    // largest legal transfer at address a: min of remaining, max and room, aligned
    function automatic logic [7:0] burst_len(input logic [31:0] a, input logic [31:0] rem,
                                             input logic [6:0] mx, input logic [7:0] room);
        logic [31:0] lim;
        logic [7:0]  l8;
        lim = rem;
        if ({dbm_pkg::PAD25, mx} < lim) begin
            lim = {dbm_pkg::PAD25, mx};
        end
        if ({dbm_pkg::PAD24, room} < lim) begin
            lim = {dbm_pkg::PAD24, room};
        end
        l8 = lim[7:0];
        if (l8 >= dbm_pkg::SZ_INCR16 && a[5:0] == 6'h00) begin
            burst_len = dbm_pkg::SZ_INCR16;
        end else if (l8 >= dbm_pkg::SZ_INCR8 && a[4:0] == 5'h00) begin
            burst_len = dbm_pkg::SZ_INCR8;
        end else if (l8 >= dbm_pkg::SZ_INCR4 && a[3:0] == 4'h0) begin
            burst_len = dbm_pkg::SZ_INCR4;
        end else if (l8 >= dbm_pkg::SZ_WORD && a[1:0] == 2'h0) begin
            burst_len = dbm_pkg::SZ_WORD;
        end else if (l8 >= dbm_pkg::SZ_HALF && a[0] == 1'b0) begin
            burst_len = dbm_pkg::SZ_HALF;
        end else if (l8 >= dbm_pkg::SZ_BYTE) begin
            burst_len = dbm_pkg::SZ_BYTE;
        end else begin
            burst_len = dbm_pkg::SZ_NONE;
        end
    endfunction : burst_len

    // round robin: first eligible channel after the last one served
    function automatic logic [2:0] pick(input logic [NCH-1:0] el, input logic [1:0] last);
        logic [1:0] c;
        pick = 3'h0;
        for (int k = NCH; k >= 1; k--) begin
            c = last + k[1:0];
            if (el[c]) begin
                pick = {1'b1, c};
            end
        end
    endfunction : pick

    function automatic logic [2:0] len_hburst(input logic [7:0] l);
        case (l)
            dbm_pkg::SZ_INCR16: len_hburst = dbm_pkg::HB_INCR16;
            dbm_pkg::SZ_INCR8:  len_hburst = dbm_pkg::HB_INCR8;
            dbm_pkg::SZ_INCR4:  len_hburst = dbm_pkg::HB_INCR4;
            default:            len_hburst = dbm_pkg::HB_SINGLE;
        endcase
    endfunction : len_hburst

    function automatic logic [1:0] len_hsize(input logic [7:0] l);
        case (l)
            dbm_pkg::SZ_BYTE: len_hsize = dbm_pkg::HS_BYTE;
            dbm_pkg::SZ_HALF: len_hsize = dbm_pkg::HS_HALF;
            default:          len_hsize = dbm_pkg::HS_WORD;
        endcase
    endfunction : len_hsize

    // per-channel burst sizing; joint channels size writes by the read limit
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rl[i]     = burst_len(ra[i], rrem[i], rmax[i], dbm_pkg::BUF_BYTES - fill[i]);
            wl[i]     = burst_len(wa[i], wrem[i], (core_joint & jbit[i]) ? rmax[i] : wmax[i],
                                  fill[i]);
            // room-free, so a fixed read/write address offset cannot keep the joint phase unreachable
            rdy_r[i]  = (burst_len(ra[i], rrem[i], rmax[i], dbm_pkg::BUF_BYTES)
                         == {1'b0, rmax[i]});
            rdy_w[i]  = (burst_len(wa[i], wrem[i], rmax[i], dbm_pkg::BUF_BYTES)
                         == {1'b0, rmax[i]});
            rd_el[i]  = ch_busy[i] & (rl[i] != dbm_pkg::SZ_NONE);
            wr_el[i]  = ch_busy[i] & (wl[i] != dbm_pkg::SZ_NONE);
            any_el[i] = rd_el[i] | wr_el[i];
        end
        rd_pick = pick(rd_el, rd_last);
        wr_pick = pick(wr_el, wr_last);
        j_pick  = pick(any_el, gnt);
    end

    // issue decisions for both arbitration styles
    always_comb begin
        rd_go         = 1'b0;
        rd_go_ch      = rd_pick[1:0];
        rd_go_len     = rl[rd_pick[1:0]];
        wr_go         = 1'b0;
        wr_go_ch      = wr_pick[1:0];
        wr_go_len     = wl[wr_pick[1:0]];
        next_jst      = jst;
        next_flushing = 1'b0;
        if (!core_joint) begin
            // separate arbiters: a read waits on write activity only through the buffer room left by fill
            rd_go    = ~rd_cmd_valid & rd_pick[2];
            wr_go    = ~wr_cmd_valid & wr_pick[2];
            next_jst = dbm_pkg::J_IDLE;
        end else begin
            rd_go_ch = gnt;
            wr_go_ch = gnt;
            rd_go_len = rl[gnt];
            wr_go_len = wl[gnt];
            case (jst)
                dbm_pkg::J_IDLE: begin
                    if (j_pick[2]) begin
                        if (last_joint & ~jbit[j_pick[1:0]]) begin
                            next_jst      = dbm_pkg::J_FLUSH;
                            next_flushing = 1'b1;
                        end else begin
                            next_jst = dbm_pkg::J_ISSUE;
                        end
                    end
                end
                dbm_pkg::J_FLUSH: begin
                    // drain every outstanding burst and buffered word first
                    next_flushing = 1'b1;
                    if (~rd_cmd_valid & ~wr_cmd_valid & ~wr_dvalid) begin
                        next_jst      = dbm_pkg::J_ISSUE;
                        next_flushing = 1'b0;
                    end
                end
                dbm_pkg::J_ISSUE: begin
                    next_jst = dbm_pkg::J_WAIT;
                    if (jbit[gnt]) begin
                        if (~rdy_r[gnt] & rd_el[gnt] & ~(rdy_w[gnt] & ~wr_el[gnt])) begin
                            rd_go = 1'b1;
                        end else if (~rdy_w[gnt] & wr_el[gnt] & rdy_r[gnt]) begin
                            wr_go = 1'b1;
                        end else if (rdy_r[gnt] & rdy_w[gnt]) begin
                            // both aligned at max: read and write together
                            rd_go     = 1'b1;
                            wr_go     = 1'b1;
                            rd_go_len = {1'b0, rmax[gnt]};
                            wr_go_len = {1'b0, rmax[gnt]};
                        end else if (rd_el[gnt]) begin
                            rd_go = 1'b1;
                        end else if (wr_el[gnt]) begin
                            wr_go = 1'b1;
                        end else begin
                            next_jst = dbm_pkg::J_IDLE;
                        end
                    end else if (rd_el[gnt]) begin
                        rd_go = 1'b1;
                    end else if (wr_el[gnt]) begin
                        wr_go = 1'b1;
                    end else begin
                        next_jst = dbm_pkg::J_IDLE;
                    end
                end
                dbm_pkg::J_WAIT: begin
                    // grant holds both buses until each burst ends, so waits cross-stall
                    if (~rd_cmd_valid & ~wr_cmd_valid) begin
                        next_jst = dbm_pkg::J_IDLE;
                    end
                end
                default: next_jst = dbm_pkg::J_IDLE;
            endcase
        end
    end

    // joint arbitration state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            jst        <= dbm_pkg::J_IDLE;
            gnt        <= 2'h0;
            last_joint <= 1'b0;
            flushing   <= 1'b0;
        end else begin
            jst      <= next_jst;
            flushing <= next_flushing;
            if (core_joint && jst == dbm_pkg::J_IDLE && j_pick[2]) begin
                gnt <= j_pick[1:0];
            end
            if (jst == dbm_pkg::J_ISSUE) begin
                last_joint <= jbit[gnt];
            end
            if (!core_joint) begin
                last_joint <= 1'b0;
            end
        end
    end

    // read command slot: held until the bus reports the burst finished
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_cmd_valid  <= 1'b0;
            rd_cmd_ch     <= 2'h0;
            rd_cmd_addr   <= 32'h0;
            rd_cmd_len    <= 8'h00;
            rd_cmd_hburst <= dbm_pkg::HB_SINGLE;
            rd_cmd_hsize  <= dbm_pkg::HS_BYTE;
            rd_last       <= 2'h3;
        end else if (rd_go) begin
            rd_cmd_valid  <= 1'b1;
            rd_cmd_ch     <= rd_go_ch;
            rd_cmd_addr   <= ra[rd_go_ch];
            rd_cmd_len    <= rd_go_len;
            rd_cmd_hburst <= len_hburst(rd_go_len);
            rd_cmd_hsize  <= len_hsize(rd_go_len);
            rd_last       <= rd_go_ch;
        end else if (rd_cmd_done) begin
            rd_cmd_valid <= 1'b0;
        end
    end

    // write command slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_cmd_valid  <= 1'b0;
            wr_cmd_ch     <= 2'h0;
            wr_cmd_addr   <= 32'h0;
            wr_cmd_len    <= 8'h00;
            wr_cmd_hburst <= dbm_pkg::HB_SINGLE;
            wr_cmd_hsize  <= dbm_pkg::HS_BYTE;
            wr_last       <= 2'h3;
        end else if (wr_go) begin
            wr_cmd_valid  <= 1'b1;
            wr_cmd_ch     <= wr_go_ch;
            wr_cmd_addr   <= wa[wr_go_ch];
            wr_cmd_len    <= wr_go_len;
            wr_cmd_hburst <= len_hburst(wr_go_len);
            wr_cmd_hsize  <= len_hsize(wr_go_len);
            wr_last       <= wr_go_ch;
        end else if (wr_cmd_done) begin
            wr_cmd_valid <= 1'b0;
        end
    end

    // per-channel command and progress; a load to a busy channel is refused
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_busy     <= 4'h0;
            ch_done     <= 4'h0;
            cmd_refused <= 1'b0;
            jbit        <= 4'h0;
            for (int i = 0; i < NCH; i++) begin
                ra[i]   <= 32'h0;
                wa[i]   <= 32'h0;
                rrem[i] <= 32'h0;
                wrem[i] <= 32'h0;
                rmax[i] <= 7'h00;
                wmax[i] <= 7'h00;
                fill[i] <= 8'h00;
            end
        end else begin
            ch_done     <= 4'h0;
            cmd_refused <= cmd_load & ch_busy[cmd_ch];
            for (int i = 0; i < NCH; i++) begin
                if (rd_cmd_valid && rd_cmd_done && rd_cmd_ch == i[1:0]) begin
                    ra[i]   <= ra[i] + {24'h0, rd_cmd_len};
                    rrem[i] <= rrem[i] - {24'h0, rd_cmd_len};
                end
                if (wr_cmd_valid && wr_cmd_done && wr_cmd_ch == i[1:0]) begin
                    wa[i]   <= wa[i] + {24'h0, wr_cmd_len};
                    wrem[i] <= wrem[i] - {24'h0, wr_cmd_len};
                end
                fill[i] <= fill[i]
                    + ((rd_cmd_valid && rd_cmd_done && rd_cmd_ch == i[1:0]) ? rd_cmd_len : 8'h00)
                    - ((wr_cmd_valid && wr_cmd_done && wr_cmd_ch == i[1:0]) ? wr_cmd_len : 8'h00);
                if (ch_busy[i] && rrem[i] == dbm_pkg::REM_ZERO && wrem[i] == dbm_pkg::REM_ZERO
                    && !(rd_cmd_valid && rd_cmd_ch == i[1:0])
                    && !(wr_cmd_valid && wr_cmd_ch == i[1:0])) begin
                    ch_busy[i] <= 1'b0;
                    ch_done[i] <= 1'b1;
                end
                if (cmd_load && cmd_ch == i[1:0] && !ch_busy[i]) begin
                    ra[i]      <= cmd_src;
                    wa[i]      <= cmd_dst;
                    rrem[i]    <= cmd_len;
                    wrem[i]    <= cmd_len;
                    rmax[i]    <= cmd_ctrl[dbm_pkg::CTL_RDMAX_LSB +: dbm_pkg::CTL_MAX_W];
                    wmax[i]    <= cmd_ctrl[dbm_pkg::CTL_WRMAX_LSB +: dbm_pkg::CTL_MAX_W];
                    jbit[i]    <= cmd_ctrl[dbm_pkg::CTL_JOINT_BIT];
                    fill[i]    <= 8'h00;
                    ch_busy[i] <= 1'b1;
                end
            end
        end
    end

    // word path from read bus to write bus; a write-side stall backs up into rd_dready
    dbm_buf #(
        .W (32)
    ) u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (rd_dvalid),
        .in_data   (rd_data),
        .in_ready  (rd_dready),
        .out_valid (wr_dvalid),
        .out_data  (wr_data),
        .out_ready (wr_dready)
    );
endmodule : dbm_core

/* File: rtl/dbm_pkg.sv */
// dbm_pkg: constants, encodings and state type shared by the burst-mode dma core.
// assumes a bus-side adapter that turns each command into one ahb burst and
// answers with a completion pulse.
package dbm_pkg;
    localparam int          NCH          = 4;
    localparam int          LW           = 8;
    localparam logic [7:0]  BUF_BYTES    = 8'h40;
    // burst and single lengths in bytes
    localparam logic [7:0]  SZ_INCR16    = 8'h40;
    localparam logic [7:0]  SZ_INCR8     = 8'h20;
    localparam logic [7:0]  SZ_INCR4     = 8'h10;
    localparam logic [7:0]  SZ_WORD      = 8'h04;
    localparam logic [7:0]  SZ_HALF      = 8'h02;
    localparam logic [7:0]  SZ_BYTE      = 8'h01;
    localparam logic [7:0]  SZ_NONE      = 8'h00;
    // ahb burst and size encodings
    localparam logic [2:0]  HB_SINGLE    = 3'h0;
    localparam logic [2:0]  HB_INCR4     = 3'h3;
    localparam logic [2:0]  HB_INCR8     = 3'h5;
    localparam logic [2:0]  HB_INCR16    = 3'h7;
    localparam logic [1:0]  HS_BYTE      = 2'h0;
    localparam logic [1:0]  HS_HALF      = 2'h1;
    localparam logic [1:0]  HS_WORD      = 2'h2;
    // control word layout
    localparam int          CTL_RDMAX_LSB = 0;
    localparam int          CTL_WRMAX_LSB = 8;
    localparam int          CTL_MAX_W     = 7;
    localparam int          CTL_JOINT_BIT = 16;
    localparam logic [31:0] REM_ZERO      = 32'h0;
    localparam logic [24:0] PAD25         = 25'h0;
    localparam logic [23:0] PAD24         = 24'h0;

    typedef enum logic [1:0] {
        J_IDLE  = 2'h0,
        J_ISSUE = 2'h1,
        J_WAIT  = 2'h3,
        J_FLUSH = 2'h2
    } dbm_jst_e;
endpackage : dbm_pkg

/* File: tb/dbm_ahb_model.sv */
// bus model: memory slaves behind the read and write command ports
// assumes commands hold until the done pulse is taken
`timescale 1ns/10ps
module dbm_ahb_model (
    input  wire logic       ref_clk,
    input  wire logic       rd_cmd_valid,
    input  wire logic [7:0] rd_cmd_len,
    output logic            rd_cmd_done,
    output logic            rd_dvalid,
    output logic [31:0]     rd_data,
    input  wire logic       rd_dready,
    input  wire logic       wr_cmd_valid,
    output logic            wr_cmd_done,
    output logic            wr_dready
);
    int seed = 32'h155f9d78;
    int n;
    initial begin
        {rd_cmd_done, rd_dvalid, rd_data} = 34'h0;
        forever begin
            @(posedge ref_clk);
            if (rd_cmd_valid === 1'b1) begin
                n = (int'(rd_cmd_len) + 3) / 4;
                repeat ($unsigned($random(seed)) % 4) @(posedge ref_clk);
                while (n > 0) begin
                    rd_dvalid <= 1'b1;
                    @(posedge ref_clk);
                    if (rd_dready) begin
                        n--;
                        rd_data <= $random(seed);
                    end
                end
                rd_dvalid <= 1'b0;
                rd_cmd_done <= 1'b1;
                @(posedge ref_clk);
                rd_cmd_done <= 1'b0;
            end
        end
    end
    // memory slave only: never a peripheral on a joint channel
    initial begin
        {wr_cmd_done, wr_dready} = 2'h0;
        forever begin
            @(posedge ref_clk);
            if (wr_cmd_valid === 1'b1) begin
                repeat ($unsigned($random(seed)) % 4) @(posedge ref_clk);
                wr_cmd_done <= 1'b1;
                @(posedge ref_clk);
                wr_cmd_done <= 1'b0;
            end
        end
    end
    always @(posedge ref_clk) wr_dready <= 1'($random(seed));
endmodule : dbm_ahb_model

/* File: tb/dbm_core_sva.sv */
// checker: command legality and handshakes of the burst core
// bound into every dbm_core; watches its ports only
`timescale 1ns/10ps
module dbm_core_sva (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        core_joint,
    input wire logic        cmd_load,
    input wire logic [1:0]  cmd_ch,
    input wire logic        rd_cmd_valid,
    input wire logic [1:0]  rd_cmd_ch,
    input wire logic [31:0] rd_cmd_addr,
    input wire logic [7:0]  rd_cmd_len,
    input wire logic [2:0]  rd_cmd_hburst,
    input wire logic        rd_cmd_done,
    input wire logic        wr_cmd_valid,
    input wire logic [1:0]  wr_cmd_ch,
    input wire logic [31:0] wr_cmd_addr,
    input wire logic [7:0]  wr_cmd_len,
    input wire logic [3:0]  ch_busy,
    input wire logic [3:0]  ch_done,
    input wire logic        cmd_refused
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_rd_align: assert property (rd_cmd_valid |->
        (rd_cmd_addr[5:0] & (rd_cmd_len[5:0] - 6'h1)) == 6'h0) else $error("read misaligned");
    a_wr_align: assert property (wr_cmd_valid |->
        (wr_cmd_addr[5:0] & (wr_cmd_len[5:0] - 6'h1)) == 6'h0) else $error("write misaligned");
    a_rd_len: assert property (rd_cmd_valid |->
        rd_cmd_len inside {8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h40}) else $error("bad length");
    a_rd_code: assert property (rd_cmd_valid && rd_cmd_len == 8'h20 |->
        rd_cmd_hburst == dbm_pkg::HB_INCR8) else $error("bad burst code");
    a_rd_hold: assert property (rd_cmd_valid && !rd_cmd_done |=>
        rd_cmd_valid && $stable(rd_cmd_addr) && $stable(rd_cmd_len)) else $error("read moved");
    a_rd_drop: assert property (rd_cmd_valid && rd_cmd_done |=>
        !rd_cmd_valid) else $error("read stays after done");
    a_load_refuse: assert property (cmd_load && ch_busy[cmd_ch] |=>
        cmd_refused) else $error("busy load not refused");
    a_load_take: assert property (cmd_load && !ch_busy[cmd_ch] |=>
        ch_busy[$past(cmd_ch)] && !cmd_refused) else $error("load not taken");
    a_done_pulse: assert property (ch_done != 4'h0 |-> (ch_done & ch_busy) == 4'h0
        ##1 (ch_done & $past(ch_done)) == 4'h0) else $error("done not a pulse");
    a_joint_one: assert property (core_joint && rd_cmd_valid && wr_cmd_valid |->
        rd_cmd_ch == wr_cmd_ch) else $error("two channels on joint core");
endmodule : dbm_core_sva

bind dbm_core dbm_core_sva u_sva (
    .ref_clk, .rst_n, .core_joint, .cmd_load, .cmd_ch, .rd_cmd_valid, .rd_cmd_ch,
    .rd_cmd_addr, .rd_cmd_len, .rd_cmd_hburst, .rd_cmd_done, .wr_cmd_valid, .wr_cmd_ch,
    .wr_cmd_addr, .wr_cmd_len, .ch_busy, .ch_done, .cmd_refused
);

/* File: tb/dma_channel_burst_modes_tb_top.sv */
// testbench: tabled and random commands in both arbitration modes
// expects the bus model at the far side and the checker bound into the core
`timescale 1ns/10ps
module dma_channel_burst_modes_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        core_joint = 1'b0;
    logic        cmd_load = 1'b0;
    logic [1:0]  cmd_ch = 2'h0;
    logic [31:0] cmd_src = 32'h0, cmd_dst = 32'h0, cmd_len = 32'h0, cmd_ctrl = 32'h0;
    logic        rd_cmd_valid, rd_cmd_done, rd_dvalid, rd_dready, wr_cmd_valid, wr_cmd_done;
    logic        wr_dvalid, wr_dready, cmd_refused, flushing;
    logic [1:0]  rd_cmd_ch, wr_cmd_ch, rd_cmd_hsize, wr_cmd_hsize;
    logic [2:0]  rd_cmd_hburst, wr_cmd_hburst;
    logic [7:0]  rd_cmd_len, wr_cmd_len;
    logic [31:0] rd_cmd_addr, wr_cmd_addr, rd_data, wr_data;
    logic [3:0]  ch_busy, ch_done;
    int          n_fail = 0, n_checks = 0, seed = 32'h155f9d78, pairs = 0, flushes = 0;
    int          nxt[2][4], rem[2][4], mx[2][4], tot[4], rdb[4], wrd[4], rdb_p[4], wrd_p[4];
    logic [31:0] wq[$];
    bit          busy_m[4], jnt[4], pv, wv;
    always #25 ref_clk = ~ref_clk;
    dbm_core dut (.*);
    dbm_ahb_model u_mem (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic burst(input int d, input logic [1:0] c, input logic [31:0] a,
            input logic [7:0] l, input logic [2:0] hb, input logic [1:0] hs);
        int r;
        int e;
        int m;
        r = rem[d][c];
        // singles are also capped by what the buffer can take or give
        m = d ? rdb_p[c] - wrd_p[c] : 64 - rdb_p[c] + wrd_p[c];
        if (r < m) m = r;
        e = (a[0] || m < 2) ? 1 : (a[1] || m < 4) ? 2 : 4;
        chk(a, nxt[d][c], "address");
        if (l < 8'h10) chk(l, e, "single width");
        else chk(a % l + (l > r) + (l > mx[d][c]), 0, "burst bounds");
        chk(hb, l == 8'h40 ? 3'h7 : l == 8'h20 ? 3'h5 : l == 8'h10 ? 3'h3 : 3'h0, "hb");
        chk(hs, l > 8'h02 ? 2'h2 : l == 8'h02 ? 2'h1 : 2'h0, "hsize");
        if (!jnt[c] && d == 0) chk(tot[c] - r + l - wrd[c] <= 64, 1, "room");
        if (!jnt[c] && d == 1) chk(tot[c] - r + l <= rdb[c], 1, "write early");
        nxt[d][c] += l;
        rem[d][c] -= l;
    endtask : burst
    always @(posedge ref_clk) begin
        if (rst_n) begin
            if (rd_cmd_valid && !pv)
                burst(0, rd_cmd_ch, rd_cmd_addr, rd_cmd_len, rd_cmd_hburst, rd_cmd_hsize);
            if (wr_cmd_valid && !wv)
                burst(1, wr_cmd_ch, wr_cmd_addr, wr_cmd_len, wr_cmd_hburst, wr_cmd_hsize);
            if (core_joint && rd_cmd_valid && !pv && wr_cmd_valid && !wv) begin
                pairs++;
                chk(rd_cmd_len + wr_cmd_len, 2 * mx[0][rd_cmd_ch], "joint pair");
            end
            rdb_p = rdb;
            wrd_p = wrd;
            if (rd_dvalid && rd_dready) wq.push_back(rd_data);
            if (wr_dvalid && wr_dready) chk(wr_data, wq.pop_front(), "data");
            if (rd_cmd_valid && rd_cmd_done) rdb[rd_cmd_ch] += rd_cmd_len;
            if (wr_cmd_valid && wr_cmd_done) wrd[wr_cmd_ch] += wr_cmd_len;
            flushes += flushing;
            for (int i = 0; i < 4; i++) if (ch_done[i]) begin
                chk(busy_m[i] && rem[0][i] == 0 && rem[1][i] == 0, 1, "finish");
                busy_m[i] = 1'b0;
            end
        end
        pv <= rd_cmd_valid;
        wv <= wr_cmd_valid;
    end
    task automatic load(input logic [1:0] c, input logic [31:0] s, input logic [31:0] d,
            input logic [31:0] l, input logic [31:0] k);
        bit b;
        @(negedge ref_clk);
        b = busy_m[c];
        {cmd_load, cmd_ch, cmd_src, cmd_dst, cmd_len, cmd_ctrl} = {1'b1, c, s, d, l, k};
        if (!b) begin
            {nxt[0][c], nxt[1][c], tot[c], rem[0][c], rem[1][c]} = {s, d, l, l, l};
            {rdb[c], wrd[c], busy_m[c], jnt[c]} = {64'h0, 1'b1, k[16]};
            mx[0][c] = k[6:0];
            mx[1][c] = k[16] ? k[6:0] : k[14:8];
        end
        @(negedge ref_clk);
        cmd_load = 1'b0;
        chk(cmd_refused, b, "refusal");
    endtask : load
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic wait_idle();
        int k;
        for (k = 0; k < 20000 && ch_busy !== 4'h0; k++) @(negedge ref_clk);
        if (k == 20000) begin
            n_fail++;
            $display("MISMATCH t=%0t channels never finished", $time);
            tally_and_finish();
        end
    endtask : wait_idle
    // memory-only channels and a 64-byte buffer: no start alignment needed
    initial begin
        logic [31:0] s;
        int l;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int t = 0; t < 6; t++) begin
            core_joint = t > 3;
            for (int c = 0; c < 4; c++) begin
                s = $random(seed);
                l = $unsigned($random(seed)) % 300 + 1;
                if (t == 0 && c == 0) load(0, 32'h30000001, 32'h40000017, 128, 32'h4040);
                else if (t == 4 && c == 0) load(0, 32'h30000031, 32'h40000037, 256, 32'h11040);
                else load(c, s, s ^ l, l, {16'h0, 8'h10 << s[9:8] % 3, 8'h10 << s[11:10] % 3});
            end
            if (t == 0) load(0, 32'h0, 32'h0, 32'h4, 32'h4040);
            wait_idle();
            if (t == 4) begin
                chk(pairs > 0, 1, "joint phase");
                chk(flushes > 0, 1, "flush stage");
            end
            $display("test %0d done, checks %0d", t, n_checks);
        end
        tally_and_finish();
    end
endmodule : dma_channel_burst_modes_tb_top
